/* File: logic/adc_result_and_reference_select.sv */
// converter select register, conversion result encoding and result byte presentation
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module adc_result_and_reference_select
    import adc_result_pkg::*;
#(
    parameter int SAMPLE_W = 12
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [adc_result_pkg::ADDR_W-1:0] i_addr,
    input wire logic [adc_result_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [adc_result_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_conv_start,
    input wire logic i_conv_done,
    input wire logic signed [SAMPLE_W-1:0] i_sample_value,
    input wire logic i_vector_taken,
    output logic [adc_result_pkg::REF_W-1:0] o_reference_select,
    output logic [adc_result_pkg::CHAN_W-1:0] o_channel_gain_select,
    output logic o_conv_busy,
    output logic o_done_flag
);
    import adc_result_pkg::*;

    if (SAMPLE_W < RESULT_W + 1 || SAMPLE_W > 16) begin : g_check
        $error("SAMPLE_W must lie between 11 and 16");
    end

    conv_state_t state_ff;
    conv_state_t nxt_state;
    logic [DATA_W-1:0] input_select_ff;
    logic [REF_W-1:0] active_ref_ff;
    logic [CHAN_W-1:0] active_chan_ff;
    logic [RESULT_W-1:0] result_ff;
    logic done_flag_ff;
    logic busy_ff;
    logic [DATA_W-1:0] rdata_ff;

    // register decode
    wire logic wr_select = i_wr && (i_addr == OFS_INPUT_SELECT);
    wire logic wr_status = i_wr && (i_addr == OFS_CONTROL_STATUS);
    wire logic rd_select = i_addr == OFS_INPUT_SELECT;
    wire logic rd_status = i_addr == OFS_CONTROL_STATUS;
    wire logic rd_low = i_addr == OFS_RESULT_LOW;
    wire logic rd_high = i_addr == OFS_RESULT_HIGH;

    // conversion sequencing seen from the converter
    wire logic conv_begin = (state_ff == ST_IDLE) && i_conv_start;
    wire logic conv_end = (state_ff == ST_CONVERT) && i_conv_done;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (conv_begin) begin
                    nxt_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (conv_end) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
    end

    // selection follows the register while idle, locked during a conversion
    wire logic sel_update = (state_ff == ST_IDLE) || conv_end;
    wire logic [REF_W-1:0] sel_ref = input_select_ff[REF_SEL_HI:REF_SEL_LO];
    wire logic [CHAN_W-1:0] sel_chan = input_select_ff[CHAN_HI:CHAN_LO];
    wire logic [REF_W-1:0] nxt_active_ref = sel_update ? sel_ref : active_ref_ff;
    wire logic [CHAN_W-1:0] nxt_active_chan = sel_update ? sel_chan : active_chan_ff;

    // channel classes: single-ended inputs, bandgap and ground are unsigned
    wire logic chan_single = (active_chan_ff <= CHAN_SINGLE_LAST)
                             || (active_chan_ff == CHAN_BANDGAP)
                             || (active_chan_ff == CHAN_GROUND);
    wire logic chan_diff = !chan_single;

    wire logic [RESULT_W-1:0] se_code;
    wire logic [RESULT_W-1:0] diff_code;

    code_saturate #(
        .IN_W(SAMPLE_W),
        .OUT_W(RESULT_W),
        .SIGNED_OUT(1'b0)
    ) u_single_sat (
        .i_value(i_sample_value),
        .o_code(se_code)
    );

    code_saturate #(
        .IN_W(SAMPLE_W),
        .OUT_W(RESULT_W),
        .SIGNED_OUT(1'b1)
    ) u_diff_sat (
        .i_value(i_sample_value),
        .o_code(diff_code)
    );

    // two's complement keeps the sign in bit 9
    wire logic [RESULT_W-1:0] conv_code = chan_diff ? diff_code : se_code;

    // done flag: hardware set wins over a clear in the same cycle
    wire logic done_clear = i_vector_taken || (wr_status && i_wdata[DONE_BIT]);
    wire logic nxt_done_flag = conv_end || (done_flag_ff && !done_clear);

    // presentation tracks the live left-adjust bit
    wire logic left_adj = input_select_ff[LEFT_ADJ_BIT];
    wire logic [DATA_W-1:0] low_byte = left_adj ? {result_ff[1:0], 6'h00}
                                                : result_ff[7:0];
    wire logic [DATA_W-1:0] high_byte = left_adj ? result_ff[9:2]
                                                 : {6'h00, result_ff[9:8]};
    wire logic [DATA_W-1:0] status_byte = 8'(({7'h00, busy_ff} << BUSY_BIT)
                                             | ({7'h00, done_flag_ff} << DONE_BIT));

    wire logic [DATA_W-1:0] rd_mux = rd_select ? input_select_ff
                                   : rd_status ? status_byte
                                   : rd_low ? low_byte
                                   : rd_high ? high_byte
                                   : RDATA_IDLE;

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= ST_IDLE;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= nxt_state == ST_CONVERT;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            input_select_ff <= INPUT_SELECT_RST;
        end else if (wr_select) begin
            input_select_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            active_ref_ff <= REF_EXTERNAL;
            active_chan_ff <= '0;
        end else begin
            active_ref_ff <= nxt_active_ref;
            active_chan_ff <= nxt_active_chan;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            result_ff <= RESULT_RST;
        end else if (conv_end) begin
            result_ff <= conv_code;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            done_flag_ff <= 1'b0;
        end else begin
            done_flag_ff <= nxt_done_flag;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff <= RDATA_IDLE;
        end else begin
            rdata_ff <= i_rd ? rd_mux : RDATA_IDLE;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_reference_select = active_ref_ff;
    assign o_channel_gain_select = active_chan_ff;
    assign o_conv_busy = busy_ff;
    assign o_done_flag = done_flag_ff;

    // checks
    sequence s_conv_end;
        (state_ff == ST_CONVERT) && i_conv_done;
    endsequence

    sequence s_write_select;
        i_wr && (i_addr == OFS_INPUT_SELECT);
    endsequence

    sequence s_read_select;
        i_rd && (i_addr == OFS_INPUT_SELECT);
    endsequence

    sequence s_read_high;
        i_rd && (i_addr == OFS_RESULT_HIGH);
    endsequence

    sequence s_read_low;
        i_rd && (i_addr == OFS_RESULT_LOW);
    endsequence

    a_result_on_done: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end |=> o_done_flag && (result_ff == $past(conv_code))
    ) else $error("result not captured with done flag");

    a_single_range: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_single && i_sample_value >= 0
                        && i_sample_value <= $signed({1'b0, SE_CODE_MAX}))
        |=> result_ff == $past(i_sample_value[RESULT_W-1:0])
    ) else $error("single-ended code wrong");

    a_single_clamp: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 chan_single
        |=> (result_ff == SE_CODE_MAX) == ($past(i_sample_value) >= 1023)
    ) else $error("single-ended clamp wrong");

    a_diff_sign: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 chan_diff
        |=> result_ff[RESULT_W-1] == ($past(i_sample_value) < 0)
    ) else $error("differential sign bit wrong");

    a_diff_sat_pos: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_diff && i_sample_value >= 511)
        |=> result_ff == DIFF_CODE_MAX
    ) else $error("positive saturation wrong");

    a_diff_sat_neg: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_diff && i_sample_value <= -512)
        |=> result_ff == DIFF_CODE_MIN
    ) else $error("negative saturation wrong");

    a_diff_near_zero: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_diff && i_sample_value == -1)
        |=> result_ff == SE_CODE_MAX
    ) else $error("minus one step code wrong");

    a_ref_locked: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        (state_ff == ST_CONVERT) && !i_conv_done
        |=> $stable(o_reference_select) && $stable(o_channel_gain_select)
    ) else $error("selection moved during conversion");

    a_ref_follows: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_write_select ##1 (state_ff == ST_IDLE)
        |=> (o_reference_select == $past(i_wdata[REF_SEL_HI:REF_SEL_LO], 2))
            && (o_channel_gain_select == $past(i_wdata[CHAN_HI:CHAN_LO], 2))
    ) else $error("selection not applied while idle");

    a_select_readback: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_write_select ##1 (s_read_select and (!i_wr))
        |=> o_rdata == $past(i_wdata, 2)
    ) else $error("select register readback wrong");

    a_high_align: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_read_high
        |=> o_rdata == ($past(left_adj) ? $past(result_ff[9:2])
                                        : {6'h00, $past(result_ff[9:8])})
    ) else $error("high byte alignment wrong");

    a_low_align: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_read_low ##0 left_adj
        |=> o_rdata[5:0] == 6'h00 && o_rdata[7:6] == $past(result_ff[1:0])
    ) else $error("low byte left form wrong");

    a_flag_clear: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        done_clear && !conv_end
        |=> !o_done_flag
    ) else $error("done flag not cleared");

    a_flag_set_wins: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 done_clear
        |=> o_done_flag [*1] ##1 (o_done_flag || done_clear || $past(done_clear))
    ) else $error("done flag lost to clear");

    a_flag_holds: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        o_done_flag && !done_clear |=> o_done_flag
    ) else $error("done flag dropped without clear");

    a_single_negative: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_single && i_sample_value < 0)
        |=> result_ff == 10'h000
    ) else $error("negative single-ended count not clamped to zero");

    a_diff_in_range: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_diff && i_sample_value >= -512
                        && i_sample_value <= 511)
        |=> result_ff == $past(i_sample_value[RESULT_W-1:0])
    ) else $error("differential code wrong inside range");

    a_diff_zero: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end ##0 (chan_diff && i_sample_value == 0)
        |=> result_ff == 10'h000
    ) else $error("zero difference code wrong");

    a_low_right: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_read_low ##0 (!left_adj)
        |=> o_rdata == $past(result_ff[7:0])
    ) else $error("low byte right form wrong");

    a_result_holds: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        !conv_end |=> $stable(result_ff)
    ) else $error("result changed without a conversion end");

    a_sel_end_load: assert property (
        @(posedge i_mclk) disable iff (!i_rstn)
        s_conv_end
        |=> (o_reference_select == $past(input_select_ff[REF_SEL_HI:REF_SEL_LO]))
            && (o_channel_gain_select == $past(input_select_ff[CHAN_HI:CHAN_LO]))
    ) else $error("selection not loaded at conversion end");

endmodule // adc_result_and_reference_select

/* File: logic/adc_result_pkg.sv */
// constants and types shared by the converter result and reference select logic
package adc_result_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int RESULT_W = 10;
    localparam int CHAN_W = 5;
    localparam int REF_W = 2;

    localparam logic [ADDR_W-1:0] OFS_INPUT_SELECT = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_CONTROL_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LOW = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH = 3'h3;

    localparam int REF_SEL_HI = 7;
    localparam int REF_SEL_LO = 6;
    localparam int LEFT_ADJ_BIT = 5;
    localparam int CHAN_HI = 4;
    localparam int CHAN_LO = 0;
    localparam int BUSY_BIT = 6;
    localparam int DONE_BIT = 4;

    localparam logic [DATA_W-1:0] INPUT_SELECT_RST = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RST = 10'h000;

    localparam logic [CHAN_W-1:0] CHAN_SINGLE_LAST = 5'h07;
    localparam logic [CHAN_W-1:0] CHAN_BANDGAP = 5'h1e;
    localparam logic [CHAN_W-1:0] CHAN_GROUND = 5'h1f;

    localparam logic [RESULT_W-1:0] SE_CODE_MAX = 10'h3ff;
    localparam logic [RESULT_W-1:0] DIFF_CODE_MAX = 10'h1ff;
    localparam logic [RESULT_W-1:0] DIFF_CODE_MIN = 10'h200;

    typedef enum logic [1:0] {
        REF_EXTERNAL = 2'b00,
        REF_ANALOG_SUPPLY = 2'b01,
        REF_RESERVED = 2'b10,
        REF_INTERNAL = 2'b11
    } ref_sel_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_CONVERT = 1'b1
    } conv_state_t;

endpackage

/* File: logic/code_saturate.sv */
// clamps a signed sample count into an unsigned or two's complement code
`timescale 1ns/1ps
module code_saturate #(
    parameter int IN_W = 12,
    parameter int OUT_W = 10,
    parameter bit SIGNED_OUT = 1'b0
) (
    input wire logic signed [IN_W-1:0] i_value,
    output logic [OUT_W-1:0] o_code
);
    localparam logic signed [IN_W-1:0] UMAX = IN_W'((1 << OUT_W) - 1);
    localparam logic signed [IN_W-1:0] SMAX = IN_W'((1 << (OUT_W - 1)) - 1);
    localparam logic signed [IN_W-1:0] SMIN = -IN_W'(1 << (OUT_W - 1));
    localparam logic signed [IN_W-1:0] LO = SIGNED_OUT ? SMIN : '0;
    localparam logic signed [IN_W-1:0] HI = SIGNED_OUT ? SMAX : UMAX;

    if (IN_W <= OUT_W) begin : g_check
        $error("code_saturate needs IN_W above OUT_W");
    end

    wire logic below = i_value < LO;
    wire logic above = i_value > HI;
    assign o_code = below ? LO[OUT_W-1:0] : (above ? HI[OUT_W-1:0] : i_value[OUT_W-1:0]);
endmodule // code_saturate

/* File: testbench/conv_partner.sv */
// behavioural analog side: answers a start request with a start pulse, then a done pulse
`timescale 1ns/1ps
module conv_partner (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_go,
    input wire logic [7:0] i_wait,
    input wire logic [11:0] i_value,
    output logic o_start,
    output logic o_done,
    output logic [11:0] o_sample
);
    logic [7:0] cnt_ff;
    logic run_ff;
    // no voltage on the reference pin; o_sample is inverted every cycle except the done cycle, which loads i_value
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= 8'h00;
            run_ff <= 1'b0;
            o_start <= 1'b0;
            o_done <= 1'b0;
            o_sample <= 12'h5a5;
        end else begin
            o_start <= i_go && !run_ff;
            o_done <= 1'b0;
            // sample is only meaningful in the done cycle, so scramble it elsewhere
            o_sample <= ~o_sample;
            if (i_go && !run_ff) begin
                run_ff <= 1'b1;
                cnt_ff <= i_wait;
            end else if (run_ff) begin
                if (cnt_ff == 8'h00) begin
                    run_ff <= 1'b0;
                    o_done <= 1'b1;
                    o_sample <= i_value;
                end else begin
                    cnt_ff <= cnt_ff - 8'h01;
                end
            end
        end
    end
endmodule // conv_partner

/* File: testbench/tb_top.sv */
// self-checking bench for the select register and result encoding
`timescale 1ns/1ps
module tb_top;
    import adc_result_pkg::*;
    typedef struct packed {
        logic [7:0] sel;
        logic [11:0] smp;
        logic [7:0] lo;
        logic [7:0] hi;
    } row_t;
    logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, vec = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, wt = 8'h00, rdata;
    logic [11:0] val = 12'h000;
    logic signed [11:0] smp;
    logic start, done, busy, flag;
    logic [1:0] refs;
    logic [4:0] chan;
    int fail_count = 0;
    int n_compared = 0;
    // row 11 selects a shorted diff pair as offset calibration would
    row_t rows [12] = '{
        '{8'h00, 12'h000, 8'h00, 8'h00}, '{8'h01, 12'h3ff, 8'hff, 8'h03},
        '{8'h02, 12'h7d0, 8'hff, 8'h03}, '{8'h23, 12'hffb, 8'h00, 8'h00},
        '{8'hed, 12'he70, 8'h00, 8'h9c}, '{8'hcd, 12'he70, 8'h70, 8'h02},
        '{8'h70, 12'h258, 8'hc0, 8'h7f}, '{8'h50, 12'hda8, 8'h00, 8'h02},
        '{8'h50, 12'hfff, 8'hff, 8'h03}, '{8'h1e, 12'h1f4, 8'hf4, 8'h01},
        '{8'h3f, 12'h000, 8'h00, 8'h00}, '{8'h88, 12'h000, 8'h00, 8'h00}};

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    adc_result_and_reference_select #(.SAMPLE_W(12)) uut (
        .i_mclk(mclk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_conv_start(start), .i_conv_done(done),
        .i_sample_value(smp), .i_vector_taken(vec), .o_reference_select(refs),
        .o_channel_gain_select(chan), .o_conv_busy(busy), .o_done_flag(flag));

    conv_partner partner (.i_mclk(mclk), .i_rstn(rstn), .i_go(go), .i_wait(wt),
        .i_value(val), .o_start(start), .o_done(done), .o_sample(smp));

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask

    task automatic kick(input logic [11:0] s, input logic [7:0] w);
        @(posedge mclk);
        val <= s;
        wt <= w;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
    endtask

    task automatic wait_done();
        int k;
        for (k = 0; k < 300 && flag !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        chk({7'h00, flag}, 8'h01, "done flag");
    endtask

    initial begin
        #(25 * 20000);
        fail_count++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        int i;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rdchk(OFS_INPUT_SELECT, 8'h00, "sel reset");
        chk({flag, busy, refs, 1'b0, 3'h0}, 8'h00, "outputs reset");
        chk({3'h0, chan}, 8'h00, "chan reset");
        for (i = 0; i < 12; i++) begin
            bus_wr(OFS_INPUT_SELECT, rows[i].sel);
            kick(rows[i].smp, 8'(i));
            wait_done();
            rdchk(OFS_RESULT_LOW, rows[i].lo, "low byte");
            rdchk(OFS_RESULT_HIGH, rows[i].hi, "high byte");
            rdchk(OFS_INPUT_SELECT, rows[i].sel, "sel readback");
            chk({6'h00, refs}, {6'h00, rows[i].sel[7:6]}, "ref out");
            chk({3'h0, chan}, {3'h0, rows[i].sel[4:0]}, "chan out");
            bus_wr(OFS_CONTROL_STATUS, 8'h10);
            rdchk(OFS_CONTROL_STATUS, 8'h00, "flag cleared");
            $display("row %0d finished", i);
        end
        // selection change while converting is held off until done
        kick(12'h0f0, 8'd20);
        bus_wr(OFS_INPUT_SELECT, 8'hc5);
        rdchk(OFS_CONTROL_STATUS, 8'h40, "busy bit");
        chk({6'h00, refs}, 8'h02, "ref frozen");
        chk({3'h0, chan}, 8'h08, "chan frozen");
        wait_done();
        chk({6'h00, refs}, 8'h03, "ref updated");
        chk({3'h0, chan}, 8'h05, "chan updated");
        rdchk(OFS_RESULT_LOW, 8'hf0, "se low");
        @(posedge mclk);
        vec <= 1'b1;
        @(posedge mclk);
        vec <= 1'b0;
        #1;
        chk({7'h00, flag}, 8'h00, "vector clears flag");
        $display("deferred selection test finished");
        // alignment flips at once, mid conversion
        kick(12'h0f0, 8'd20);
        bus_wr(OFS_INPUT_SELECT, 8'he5);
        rdchk(OFS_RESULT_HIGH, 8'h3c, "left high live");
        rdchk(OFS_RESULT_LOW, 8'h00, "left low live");
        wait_done();
        $display("live alignment test finished");
        // a clear in the done cycle loses to the set
        bus_wr(OFS_CONTROL_STATUS, 8'h10);
        kick(12'h0f0, 8'd2);
        repeat (3) @(posedge mclk);
        vec <= 1'b1;
        @(posedge mclk);
        vec <= 1'b0;
        #1;
        chk({7'h00, flag}, 8'h01, "set beats clear");
        // write then read with no gap
        @(posedge mclk);
        addr <= OFS_INPUT_SELECT;
        wdata <= 8'h65;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(rdata, 8'h65, "back to back readback");
        $display("set priority and back to back test finished");
        bus_wr(3'h5, 8'hff);
        rdchk(3'h5, 8'h00, "unmapped read");
        bus_wr(OFS_RESULT_HIGH, 8'h55);
        rdchk(OFS_RESULT_HIGH, 8'h3c, "result write ignored");
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        rdchk(OFS_INPUT_SELECT, 8'h00, "sel second reset");
        chk({flag, busy, refs, 1'b0, 3'h0}, 8'h00, "outputs second reset");
        chk({3'h0, chan}, 8'h00, "chan second reset");
        $display("refusal and reset test finished");
        tally_and_finish();
    end
endmodule // tb_top
